// ---- hw/p5sc_pkg.sv ----
// package: constants and carrier types for the port-5 strap loader
package p5sc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STRAP   = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;

  // ---------------------------------------------------------------
  // strap word field positions
  // ---------------------------------------------------------------
  localparam int BIT_FC_DIS      = 0;
  localparam int BIT_BP_EN       = 1;
  localparam int BIT_KEEP_COL    = 2;
  localparam int BIT_AGGR_BO     = 3;
  localparam int BIT_BIG_FRAME   = 4;
  localparam int BIT_P4_FULL     = 5;
  localparam int BIT_P4_FORCE_FC = 6;
  localparam int BIT_IF_EN       = 7;
  localparam int BIT_FMODE_A     = 8;
  localparam int BIT_FMODE_B     = 9;

  // ctrl / status bits
  localparam int BIT_CTRL_LOOP   = 0;
  localparam int BIT_ST_PDOWN    = 0;
  localparam int BIT_ST_RALB     = 1;
  localparam int BIT_ST_PSAVE    = 2;
  localparam int BIT_ST_LINKEN   = 3;

  // ---------------------------------------------------------------
  // frame limits and clock division
  // ---------------------------------------------------------------
  localparam logic [10:0] FRAME_MAX_STD = 11'd1522;
  localparam logic [10:0] FRAME_MAX_BIG = 11'd1536;
  localparam int          LINK_DIV_HALF = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       fmode_b;
    logic       fmode_a;
    logic       if_en;
    logic       p4_force_fc;
    logic       p4_full;
    logic       big_frame;
    logic       aggr_bo;
    logic       keep_col;
    logic       bp_en;
    logic       fc_dis;
  } p5sc_strap_t;

  typedef struct packed {
    logic       valid;
    logic       error;
    logic [3:0] data;
  } p5sc_mii_t;

  typedef enum logic [1:0] {
    FMODE_NORMAL,
    FMODE_RALB,
    FMODE_RSVD,
    FMODE_PSAVE
  } p5sc_fmode_t;

endpackage : p5sc_pkg

// ---- hw/p5sc_link.sv ----
// module: link-clock side of the port-5 interface
`timescale 1ns/1ps
module p5sc_link (
  // clock and reset
  input  wire logic                 link_clk_in,
  input  wire logic                 reset_n_in,
  // control, from the core domain, synchronised below
  input  wire logic                 loop_in,
  // interface pins
  input  wire p5sc_pkg::p5sc_mii_t  tx_in,
  output p5sc_pkg::p5sc_mii_t       rx_out
);

  // ---------------------------------------------------------------
  // sampling of mac-driven inputs and the loop control
  // ---------------------------------------------------------------
  p5sc_pkg::p5sc_mii_t tx_s1;
  p5sc_pkg::p5sc_mii_t tx_s2;
  logic                loop_s1;
  logic                loop_s2;

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_s1   <= '0;
      tx_s2   <= '0;
      loop_s1 <= 1'b0;
      loop_s2 <= 1'b0;
    end else begin
      tx_s1   <= tx_in;
      tx_s2   <= tx_s1;
      loop_s1 <= loop_in;
      loop_s2 <= loop_s1;
    end
  end

  // ---------------------------------------------------------------
  // receive path register: loopback or idle
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_out <= '0;
    end else if (loop_s2) begin
      rx_out <= tx_s2;
    end else begin
      rx_out <= '0;
    end
  end

endmodule : p5sc_link

// ---- hw/p5sc_top.sv ----
// module: port-5 strap capture, pin direction and register slave
//
// Operation
// - Dual-use pins are pulled-down inputs in reset and driven outputs after.
// - Receive bit 3 strap low enables flow control, high disables it.
// - Receive bit 2 strap low disables back pressure, high enables it.
// - Receive bit 1 strap low drops excess-collision frames, high keeps them.
// - Receive bit 0 strap high enables aggressive half-duplex back-off.
// - Receive error strap picks a 1522/1518 byte or 1536 byte frame limit.
// - Carrier-sense strap picks port 4 fallback duplex, half low, full high.
// - Collision strap high forces flow control on port 4.
// - Factory pins decode 0/1 loopback, 1/1 power save, 1/0 reserved.
// - Low on the power-down input powers the chip down; undriven is normal.
// - The device sources both the transmit and receive interface clocks.
// - After reset the device drives valid, data, error, carrier and collision.
// - Middle led strap high enables the interface, low tristates its outputs.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module p5sc_top #(
  parameter int LINK_DIV = p5sc_pkg::LINK_DIV_HALF
) (
  // clock, reset, enable
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 clk_en_in,
  // link clock from the clock generator
  input  wire logic                 link_clk_in,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // chip-level pins
  input  wire logic                 chip_power_down_n,
  input  wire logic                 factory_mode_pin_a,
  input  wire logic                 factory_mode_pin_b,
  input  wire logic                 port5_led_mid_strap,
  // transmit side from the mac
  input  wire logic                 p5_tx_enable_in,
  input  wire logic [3:0]           p5_tx_data_in,
  input  wire logic                 p5_tx_error_in,
  // clocks toward the mac
  output logic                      p5_tx_clock_out,
  output logic                      p5_tx_clock_oe_n_out,
  output logic                      p5_rx_clock_out,
  output logic                      p5_rx_clock_oe_n_out,
  // dual-use receive pins: input, output, enable (low = driving)
  input  wire logic                 p5_rx_valid_in,
  input  wire logic [3:0]           p5_rx_data_in,
  input  wire logic                 p5_rx_error_in,
  input  wire logic                 p5_carrier_sense_in,
  input  wire logic                 p5_collision_in,
  output logic                      p5_rx_valid_out,
  output logic      [3:0]           p5_rx_data_out,
  output logic                      p5_rx_error_out,
  output logic                      p5_carrier_sense_out,
  output logic                      p5_collision_out,
  output logic                      p5_rx_oe_n_out,
  output logic                      p5_rx_pulldown_out,
  // captured configuration
  output p5sc_pkg::p5sc_strap_t     strap_out,
  output logic      [10:0]          frame_max_out,
  output logic                      chip_powered_down_out,
  output p5sc_pkg::p5sc_fmode_t     factory_mode_out
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PINS = 12;
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_s1;
  logic [PINS-1:0] pin_s2;

  assign pin_raw = {port5_led_mid_strap, factory_mode_pin_b,
                    factory_mode_pin_a, chip_power_down_n,
                    p5_collision_in, p5_carrier_sense_in, p5_rx_error_in,
                    p5_rx_data_in, p5_rx_valid_in};

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (clk_en_in) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  logic [1:0]            rel_cnt;
  logic                  captured;
  p5sc_pkg::p5sc_strap_t strap;
  p5sc_pkg::p5sc_strap_t next_strap;

  always_comb begin
    next_strap             = '0;
    next_strap.fc_dis      = pin_s2[4];
    next_strap.bp_en       = pin_s2[3];
    next_strap.keep_col    = pin_s2[2];
    next_strap.aggr_bo     = pin_s2[1];
    next_strap.big_frame   = pin_s2[5];
    next_strap.p4_full     = pin_s2[6];
    next_strap.p4_force_fc = pin_s2[7];
    next_strap.if_en       = pin_s2[11];
    next_strap.fmode_a     = pin_s2[9];
    next_strap.fmode_b     = pin_s2[10];
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rel_cnt  <= 2'h0;
      captured <= 1'b0;
      strap    <= '0;
    end else if (clk_en_in && !captured) begin
      if (rel_cnt == 2'h2) begin
        strap    <= next_strap;
        captured <= 1'b1;
      end else begin
        rel_cnt <= rel_cnt + 2'h1;
      end
    end
  end

  assign strap_out = strap;

  always_comb begin
    frame_max_out = strap.big_frame ? p5sc_pkg::FRAME_MAX_BIG
                                    : p5sc_pkg::FRAME_MAX_STD;
  end

  // ---------------------------------------------------------------
  // factory mode and power down
  // ---------------------------------------------------------------
  function automatic p5sc_pkg::p5sc_fmode_t decode_fmode(
    input logic a,
    input logic b
  );
    case ({a, b})
      2'b01:   decode_fmode = p5sc_pkg::FMODE_RALB;
      2'b10:   decode_fmode = p5sc_pkg::FMODE_RSVD;
      2'b11:   decode_fmode = p5sc_pkg::FMODE_PSAVE;
      default: decode_fmode = p5sc_pkg::FMODE_NORMAL;
    endcase
  endfunction : decode_fmode

  assign factory_mode_out = decode_fmode(strap.fmode_a, strap.fmode_b);

  logic pdown;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pdown <= 1'b0;
    end else if (clk_en_in && captured) begin
      pdown <= !pin_s2[8];
    end
  end
  assign chip_powered_down_out = pdown;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic       ctrl_loop;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic       rd_pend;
  logic       acc;

  assign acc = hsel && hready && htrans == p5sc_pkg::HTRANS_NONSEQ;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else if (clk_en_in && hready) begin
      wr_pend <= acc && hwrite;
      rd_pend <= acc && !hwrite;
      wr_addr <= haddr[7:0];
      rd_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_loop <= 1'b0;
    end else if (clk_en_in && wr_pend &&
                 wr_addr == p5sc_pkg::ADDR_CTRL) begin
      ctrl_loop <= hwdata[p5sc_pkg::BIT_CTRL_LOOP];
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      p5sc_pkg::ADDR_STRAP:
        next_rdata[9:0] = strap;
      p5sc_pkg::ADDR_CTRL:
        next_rdata[p5sc_pkg::BIT_CTRL_LOOP] = ctrl_loop;
      p5sc_pkg::ADDR_STATUS: begin
        next_rdata[p5sc_pkg::BIT_ST_PDOWN]  = pdown;
        next_rdata[p5sc_pkg::BIT_ST_RALB]   =
          factory_mode_out == p5sc_pkg::FMODE_RALB;
        next_rdata[p5sc_pkg::BIT_ST_PSAVE]  =
          factory_mode_out == p5sc_pkg::FMODE_PSAVE;
        next_rdata[p5sc_pkg::BIT_ST_LINKEN] = captured && strap.if_en;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en_in && acc && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // interface clocks, divided from the core clock
  // ---------------------------------------------------------------
  logic [7:0] div_cnt;
  logic       mii_clk;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt <= 8'h00;
      mii_clk <= 1'b0;
    end else if (clk_en_in) begin
      if (div_cnt == 8'(LINK_DIV - 1)) begin
        div_cnt <= 8'h00;
        mii_clk <= !mii_clk;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // link-domain data path
  // ---------------------------------------------------------------
  p5sc_pkg::p5sc_mii_t tx_bus;
  p5sc_pkg::p5sc_mii_t rx_bus;

  assign tx_bus = '{valid: p5_tx_enable_in, error: p5_tx_error_in,
                    data: p5_tx_data_in};

  p5sc_link u_link (
    .link_clk_in (link_clk_in),
    .reset_n_in  (reset_n_in),
    .loop_in     (ctrl_loop),
    .tx_in       (tx_bus),
    .rx_out      (rx_bus)
  );

  // ---------------------------------------------------------------
  // pin direction
  // ---------------------------------------------------------------
  logic drive;
  assign drive = captured && strap.if_en;

  assign p5_rx_pulldown_out   = !captured;
  assign p5_rx_oe_n_out       = !drive;
  assign p5_tx_clock_oe_n_out = !drive;
  assign p5_rx_clock_oe_n_out = !drive;
  assign p5_tx_clock_out      = mii_clk;
  assign p5_rx_clock_out      = mii_clk;

  assign p5_rx_valid_out      = rx_bus.valid;
  assign p5_rx_data_out       = rx_bus.data;
  assign p5_rx_error_out      = rx_bus.error;
  assign p5_carrier_sense_out = rx_bus.valid;
  assign p5_collision_out     = rx_bus.valid && tx_bus.valid;

endmodule : p5sc_top

// ---- verification/p5sc_properties.sv ----
// checker: port-level properties of the port-5 strap loader
`timescale 1ns/1ps
module p5sc_chk #(
  parameter int LINK_DIV = 2
) (
  // clock, reset, bus
  input wire logic                  core_clk_in,
  input wire logic                  reset_n_in,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  // pins and captured state
  input wire logic                  chip_power_down_n,
  input wire logic                  p5_tx_enable_in,
  input wire logic                  p5_tx_clock_out,
  input wire logic                  p5_rx_clock_out,
  input wire logic                  p5_rx_valid_out,
  input wire logic                  p5_carrier_sense_out,
  input wire logic                  p5_collision_out,
  input wire logic                  p5_rx_oe_n_out,
  input wire logic                  p5_rx_pulldown_out,
  input wire p5sc_pkg::p5sc_strap_t strap_out,
  input wire logic [10:0]           frame_max_out,
  input wire logic                  chip_powered_down_out,
  input wire p5sc_pkg::p5sc_fmode_t factory_mode_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_cap;
    !p5_rx_pulldown_out ##1 !p5_rx_pulldown_out;
  endsequence

  property p_pull;
    $rose(reset_n_in) |-> (p5_rx_pulldown_out && p5_rx_oe_n_out) [*3]
      ##1 !p5_rx_pulldown_out;
  endproperty
  a_pull: assert property (p_pull) else $error("pin mode at release");
  property p_oe;
    s_cap |-> p5_rx_oe_n_out == !strap_out.if_en;
  endproperty
  a_oe: assert property (p_oe) else $error("rx enable wrong");
  property p_hold;
    s_cap |-> $stable(strap_out);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed");
  property p_frame;
    s_cap |-> frame_max_out == (strap_out.big_frame ?
      p5sc_pkg::FRAME_MAX_BIG : p5sc_pkg::FRAME_MAX_STD);
  endproperty
  a_frame: assert property (p_frame) else $error("frame limit wrong");
  property p_fmode;
    s_cap |-> factory_mode_out ==
      p5sc_pkg::p5sc_fmode_t'({strap_out.fmode_a, strap_out.fmode_b});
  endproperty
  a_fmode: assert property (p_fmode) else $error("factory mode wrong");
  property p_read;
    hsel && hready && htrans == p5sc_pkg::HTRANS_NONSEQ && !hwrite &&
      haddr == 32'(p5sc_pkg::ADDR_STRAP) && !p5_rx_pulldown_out
      |=> hrdata == {22'h0, strap_out};
  endproperty
  a_read: assert property (p_read) else $error("strap read wrong");
  property p_pdown;
    $stable(chip_power_down_n) [*4] ##0 !p5_rx_pulldown_out
      |-> chip_powered_down_out == !chip_power_down_n;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down wrong");
  property p_crs;
    !p5_rx_oe_n_out |-> p5_carrier_sense_out == p5_rx_valid_out &&
      p5_collision_out == (p5_rx_valid_out && p5_tx_enable_in);
  endproperty
  a_crs: assert property (p_crs) else $error("carrier or collision");
  // half period of two core cycles at the default divider
  property p_clk;
    $changed(p5_tx_clock_out) |=> $stable(p5_tx_clock_out) ##1
      ($changed(p5_tx_clock_out) && p5_rx_clock_out == p5_tx_clock_out);
  endproperty
  a_clk: assert property (p_clk) else $error("interface clock wrong");
endmodule : p5sc_chk

// ---- verification/p5sc_mac_model.sv ----
// model: external mac on the port-5 interface
`timescale 1ns/1ps
module p5sc_mac_model (
  // link clock and control
  input  wire logic             link_clk_in,
  input  wire logic             run_in,
  // receive pins, both parties
  input  wire logic             oe_n_in,
  input  wire logic [7:0]       drv_in,
  input  wire logic [7:0]       strap_in,
  output logic      [7:0]       pin_out,
  // transmit pins toward the device
  output p5sc_pkg::p5sc_mii_t   tx_out
);
  integer      sd = 80;
  logic [31:0] r;
  assign pin_out = oe_n_in ? strap_in : drv_in;
  initial tx_out = '0;
  always @(posedge link_clk_in) begin
    r = $random(sd);
    tx_out <= (run_in && r[4]) ? {1'b1, r[5], r[3:0]} : '0;
  end
endmodule : p5sc_mac_model

// ---- verification/p5sc_tb.sv ----
// testbench: strap capture, register and loopback checks
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        core_clk_in, link_clk_in, reset_n_in, clk_en_in, hresp;
  logic        hsel, hwrite, hready, hreadyout, p5_tx_clock_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        chip_power_down_n, factory_mode_pin_a, factory_mode_pin_b;
  logic        port5_led_mid_strap, p5_tx_enable_in, p5_tx_error_in;
  logic [3:0]  p5_tx_data_in, p5_rx_data_in, p5_rx_data_out;
  logic        p5_tx_clock_oe_n_out, p5_rx_clock_out, p5_rx_clock_oe_n_out;
  logic        p5_rx_valid_in, p5_rx_error_in, p5_carrier_sense_in;
  logic        p5_collision_in, p5_rx_valid_out, p5_rx_error_out;
  logic        p5_carrier_sense_out, p5_collision_out, p5_rx_oe_n_out;
  logic        p5_rx_pulldown_out, chip_powered_down_out;
  logic [10:0] frame_max_out;
  logic [7:0]  pin, strap;
  logic [9:0]  sv;
  int          failures, n_compared, cyc, lbm, i, seed;
  p5sc_pkg::p5sc_strap_t strap_out;
  p5sc_pkg::p5sc_fmode_t factory_mode_out;
  p5sc_pkg::p5sc_mii_t   tx, rx_exp;
  p5sc_pkg::p5sc_mii_t   q[$];

  assign hready = hreadyout;
  assign {p5_tx_enable_in, p5_tx_error_in, p5_tx_data_in} = tx;
  assign {p5_collision_in, p5_carrier_sense_in, p5_rx_error_in,
          p5_rx_valid_in, p5_rx_data_in} = pin;

  p5sc_top dut (.*);
  p5sc_mac_model mac (
    .link_clk_in, .run_in(lbm != 0), .oe_n_in(p5_rx_oe_n_out),
    .drv_in({p5_collision_out, p5_carrier_sense_out, p5_rx_error_out,
             p5_rx_valid_out, p5_rx_data_out}),
    .strap_in(strap), .pin_out(pin), .tx_out(tx)
  );

  always #4 core_clk_in = ~core_clk_in;
  initial begin
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end

  task chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task bus(input logic w, input logic [31:0] a, d);
    @(posedge core_clk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= p5sc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask : bus

  task test_done();
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // loopback reference: rx shows the nibble sampled two link edges before
  // ---------------------------------------------------------------
  always @(posedge link_clk_in) begin
    if (lbm == 1) q.push_back(tx);
    else q.delete();
    #1;
    if (lbm == 2 || q.size() > 2) begin
      rx_exp = (lbm == 2) ? '0 : q[q.size()-3];
      chk("rx", rx_exp, {p5_rx_valid_out, p5_rx_error_out,
          p5_rx_data_out});
      chk("col", rx_exp.valid & tx.valid, p5_collision_out);
    end
  end

  initial begin
    seed = 80;
    {core_clk_in, link_clk_in, reset_n_in, clk_en_in} = 4'h1;
    {hsel, hwrite, htrans, haddr, hwdata, strap} = '0;
    hsize = p5sc_pkg::HSIZE_WORD;
    chip_power_down_n = 1'b1;
    {factory_mode_pin_b, factory_mode_pin_a, port5_led_mid_strap} = 3'h0;
    for (i = 0; i < 4; i++) begin
      sv = 10'($random(seed));
      sv[9:8] = i[1:0];
      sv[7] = (i != 1);
      @(posedge core_clk_in);
      reset_n_in <= 1'b0;
      strap <= {sv[6], sv[5], sv[4], 1'b0, sv[0], sv[1], sv[2], sv[3]};
      {factory_mode_pin_b, factory_mode_pin_a, port5_led_mid_strap} <= sv[9:7];
      repeat (2) @(posedge core_clk_in);
      chk("rst_pins", 2'h3, {p5_rx_oe_n_out, p5_rx_pulldown_out});
      reset_n_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      chk("strap", sv, strap_out);
      chk("frame", sv[4] ? p5sc_pkg::FRAME_MAX_BIG : p5sc_pkg::FRAME_MAX_STD,
          frame_max_out);
      chk("fmode", {sv[8], sv[9]}, factory_mode_out);
      chk("oe", {1'b0, !sv[7]}, {p5_rx_pulldown_out, p5_rx_oe_n_out});
      chk("clk_oe", {2{!sv[7]}}, {p5_tx_clock_oe_n_out,
          p5_rx_clock_oe_n_out});
      bus(1'b0, 32'(p5sc_pkg::ADDR_STRAP), 32'h0);
      chk("rd_strap", {22'h0, sv}, rd);
      strap <= ~strap;
      {factory_mode_pin_b, factory_mode_pin_a, port5_led_mid_strap} <= ~sv[9:7];
      bus(1'b1, 32'(p5sc_pkg::ADDR_STRAP), 32'hffffffff);
      bus(1'b0, 32'(p5sc_pkg::ADDR_STRAP), 32'h0);
      chk("hold", {22'h0, sv}, rd);
    end
    bus(1'b0, 32'(p5sc_pkg::ADDR_CTRL), 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    chip_power_down_n <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    chk("pdown", 1'b1, chip_powered_down_out);
    bus(1'b0, 32'(p5sc_pkg::ADDR_STATUS), 32'h0);
    chk("status", 32'hd, rd);
    chip_power_down_n <= 1'b1;
    bus(1'b0, 32'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 32'(p5sc_pkg::ADDR_CTRL), 32'h1);
    bus(1'b0, 32'(p5sc_pkg::ADDR_CTRL), 32'h0);
    chk("ctrl", 32'h1, rd);
    repeat (10) @(posedge link_clk_in);
    #20 lbm = 1;
    repeat (200) @(posedge link_clk_in);
    #20 lbm = 3;
    bus(1'b1, 32'(p5sc_pkg::ADDR_CTRL), 32'h0);
    repeat (10) @(posedge link_clk_in);
    #20 lbm = 2;
    repeat (50) @(posedge link_clk_in);
    test_done();
  end
endmodule : testbench

bind p5sc_top p5sc_chk #(.LINK_DIV(LINK_DIV)) u_chk (.*);
